/* File: hdl/tbt_pkg.sv */
// Function
// - Count register is software read/write and clears to zero on any reset.
// - Prescaler divides instruction clock by 1 (00), 4 (01) or 16 (1x).
// - Four-bit postscaler emits one event every 1 to 16 period matches.
// - Each postscaler event latches the match flag at status bit 3.
// - Count write, control write and reset clear prescaler and postscaler counters.
// - A control register write leaves the count value unchanged.
// - Timer counts while control bit 2 is one and halts while zero.
// - Eight-bit period register is read/write and resets to FFh.
// - Count runs from 00h to period, then returns to 00h signalling a match.
// - Pre-postscaler match goes only to the PWM modules as their time base.
// - The time base is offered only to modules operating in PWM mode.
// - Control register bit 7 is unimplemented and reads as zero.
package tbt_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int          ADDR_W        = 3;
   localparam int          DATA_W        = 8;
   localparam logic [2:0]  OFS_CONTROL   = 3'h0;
   localparam logic [2:0]  OFS_COUNT     = 3'h1;
   localparam logic [2:0]  OFS_PERIOD    = 3'h2;
   localparam logic [2:0]  OFS_STATUS    = 3'h3;
   localparam logic [2:0]  OFS_MASK      = 3'h4;

   // ----------------------------------------------------------------
   // Fields and reset values
   // ----------------------------------------------------------------
   localparam int          FLAG_BIT      = 3;
   localparam int          CTRL_W        = 7;
   localparam logic [7:0]  PERIOD_RST    = 8'hFF;
   localparam logic [7:0]  COUNT_RST     = 8'h00;
   localparam logic [6:0]  CONTROL_RST   = 7'h00;
   localparam logic [7:0]  FLAG_MASK     = 8'h08;

   // ----------------------------------------------------------------
   // Prescaler terminal counts (divide minus one)
   // ----------------------------------------------------------------
   localparam logic [3:0]  PRE_LAST_DIV1  = 4'h0;
   localparam logic [3:0]  PRE_LAST_DIV4  = 4'h3;
   localparam logic [3:0]  PRE_LAST_DIV16 = 4'hF;

   typedef struct packed {
      logic [3:0] postscale_select;
      logic       timer_on;
      logic [1:0] prescale_select;
   } tbt_ctrl_t;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } tbt_bus_req_t;

endpackage

/* File: hdl/tbt_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module tbt_prescaler
   import tbt_pkg::*;
(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // Control
   input  wire logic       clear,
   input  wire logic       enable,
   input  wire logic [1:0] sel,
   // Tick out
   output logic            tick
);

   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   logic [3:0] last;

   // ----------------------------------------------------------------
   // Division select
   // ----------------------------------------------------------------
   assign last     = sel[1] ? PRE_LAST_DIV16 :
                     (sel[0] ? PRE_LAST_DIV4 : PRE_LAST_DIV1);
   assign tick     = enable && !clear && (cnt_reg == last);
   assign cnt_next = (clear || tick) ? 4'h0 :
                     (enable ? cnt_reg + 4'h1 : cnt_reg);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt_reg <= 4'h0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   pre_clear_a: assert property (clear |=> cnt_reg == 4'h0)
      else $error("prescaler not cleared");
   pre_div1_a: assert property (enable && !clear && sel == 2'h0 |-> tick)
      else $error("divide by one missed a tick");
   pre_div4_a: assert property (
      tick && sel == 2'h1 ##1 (enable && !clear && $stable(sel))[*3]
      |-> !tick ##1 (enable && !clear) |-> tick)
      else $error("divide by four spacing wrong");

endmodule
`default_nettype wire

/* File: hdl/tbt_postscaler.sv */
`timescale 1ns/1ps
`default_nettype none
module tbt_postscaler
   import tbt_pkg::*;
(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // Control
   input  wire logic       clear,
   input  wire logic       match,
   input  wire logic [3:0] sel,
   // Event out
   output logic            post_event
);

   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;

   // Count of matches seen, compared with select (0 means every match)
   assign post_event = match && !clear && (cnt_reg == sel);
   assign cnt_next   = (clear || post_event) ? 4'h0 :
                       (match ? cnt_reg + 4'h1 : cnt_reg);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt_reg <= 4'h0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   post_every_a: assert property (match && !clear && sel == 4'h0 |-> post_event)
      else $error("postscale one to one missed event");
   post_clear_a: assert property (clear |=> cnt_reg == 4'h0)
      else $error("postscaler not cleared");
   post_limit_a: assert property (post_event |-> cnt_reg == sel)
      else $error("postscaler event at wrong count");

endmodule
`default_nettype wire

/* File: hdl/tbt_timer.sv */
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module tbt_timer
   import tbt_pkg::*;
#(
   parameter int NUM_PWM = 2
)(
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               rst,
   // Register port
   input  wire tbt_bus_req_t       bus_req,
   output logic [DATA_W-1:0]       rdata,
   // Capture/compare/PWM modules
   input  wire logic [NUM_PWM-1:0] pwm_mode,
   output logic [NUM_PWM-1:0]      pwm_time_base,
   // Interrupt
   output logic                    irq
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   tbt_ctrl_t          ctrl_reg;
   logic [7:0]         count_reg;
   logic [7:0]         count_next;
   logic [7:0]         period_reg;
   logic               flag_reg;
   logic               flag_next;
   logic               enable_reg;
   logic               irq_reg;
   logic               match_reg;
   logic [DATA_W-1:0]  rdata_reg;
   logic [DATA_W-1:0]  rdata_next;
   logic [NUM_PWM-1:0] pwm_tb_reg;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic logic hit(input tbt_bus_req_t r, input logic [ADDR_W-1:0] ofs);
      hit = (r.addr == ofs);
   endfunction

   logic wr_ctrl;
   logic wr_count;
   logic wr_period;
   logic wr_status;
   logic wr_mask;
   logic scaler_clear;
   logic pre_tick;
   logic period_hit;
   logic match;
   logic post_event;

   assign wr_ctrl      = bus_req.wr && hit(bus_req, OFS_CONTROL);
   assign wr_count     = bus_req.wr && hit(bus_req, OFS_COUNT);
   assign wr_period    = bus_req.wr && hit(bus_req, OFS_PERIOD);
   assign wr_status    = bus_req.wr && hit(bus_req, OFS_STATUS);
   assign wr_mask      = bus_req.wr && hit(bus_req, OFS_MASK);
   assign scaler_clear = wr_count || wr_ctrl;

   // ----------------------------------------------------------------
   // Prescaler and postscaler
   // ----------------------------------------------------------------
   tbt_prescaler u_pre (
      .core_clk (core_clk),
      .rst      (rst),
      .clear    (scaler_clear),
      .enable   (ctrl_reg.timer_on),
      .sel      (ctrl_reg.prescale_select),
      .tick     (pre_tick)
   );

   tbt_postscaler u_post (
      .core_clk   (core_clk),
      .rst        (rst),
      .clear      (scaler_clear),
      .match      (match),
      .sel        (ctrl_reg.postscale_select),
      .post_event (post_event)
   );

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   // A control write clears only the scalers, so its tick is blocked too,
   // keeping the count exactly as it was.
   assign period_hit = (count_reg == period_reg);
   assign match      = pre_tick && period_hit && !wr_ctrl;
   assign count_next = wr_count ? bus_req.wdata :
                       wr_ctrl  ? count_reg :
                       !pre_tick ? count_reg :
                       period_hit ? COUNT_RST : count_reg + 8'h01;

   // Software clear loses to a new event arriving in the same cycle
   assign flag_next  = post_event ||
                       (flag_reg && !(wr_status && bus_req.wdata[FLAG_BIT]));

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl_reg   <= CONTROL_RST;
         count_reg  <= COUNT_RST;
         period_reg <= PERIOD_RST;
         flag_reg   <= 1'b0;
         enable_reg <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= bus_req.wdata[CTRL_W-1:0];
         end
         if (wr_period) begin
            period_reg <= bus_req.wdata;
         end
         if (wr_mask) begin
            enable_reg <= bus_req.wdata[FLAG_BIT];
         end
         count_reg <= count_next;
         flag_reg  <= flag_next;
      end
   end

   // ----------------------------------------------------------------
   // Time base to PWM modules
   // ----------------------------------------------------------------
   // Only modules in PWM mode see the match; there is no serial baud tap.
   genvar g;
   generate
      for (g = 0; g < NUM_PWM; g++) begin : g_tb
         always_ff @(posedge core_clk) begin
            if (rst) begin
               pwm_tb_reg[g] <= 1'b0;
            end else begin
               pwm_tb_reg[g] <= match && pwm_mode[g];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Read port and interrupt
   // ----------------------------------------------------------------
   always_comb begin
      rdata_next = '0;
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            OFS_CONTROL: rdata_next = {1'b0, ctrl_reg};
            OFS_COUNT:   rdata_next = count_reg;
            OFS_PERIOD:  rdata_next = period_reg;
            OFS_STATUS:  rdata_next = flag_reg ? FLAG_MASK : 8'h00;
            OFS_MASK:    rdata_next = enable_reg ? FLAG_MASK : 8'h00;
            default:     rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata_reg <= 8'h00;
         irq_reg   <= 1'b0;
         match_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         irq_reg   <= flag_reg && enable_reg;
         match_reg <= match;
      end
   end

   assign rdata         = rdata_reg;
   assign irq           = irq_reg;
   assign pwm_time_base = pwm_tb_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   count_write_a: assert property (wr_count |=> count_reg == $past(bus_req.wdata))
      else $error("count write not stored");
   ctrl_keeps_a: assert property (wr_ctrl && !wr_count |=> $stable(count_reg))
      else $error("control write changed count");
   halt_a: assert property (!ctrl_reg.timer_on && !wr_count |=> $stable(count_reg))
      else $error("count moved while off");
   wrap_zero_a: assert property (
      pre_tick && period_hit && !wr_count && !wr_ctrl |=> count_reg == 8'h00 && match_reg)
      else $error("count did not wrap at period");
   count_inc_a: assert property (
      pre_tick && !period_hit && !wr_count && !wr_ctrl
      |=> count_reg == $past(count_reg) + 8'h01)
      else $error("count did not increment");
   period_write_a: assert property (wr_period |=> period_reg == $past(bus_req.wdata))
      else $error("period write not stored");
   ctrl_msb_a: assert property (bus_req.rd && bus_req.addr == OFS_CONTROL |=> !rdata[7])
      else $error("control bit 7 read non-zero");
   flag_set_a: assert property (post_event |=> flag_reg)
      else $error("flag missed postscaler event");
   flag_hold_a: assert property (flag_reg && !wr_status |=> flag_reg)
      else $error("flag dropped without clear");
   irq_follow_a: assert property (##1 irq == $past(flag_reg && enable_reg))
      else $error("interrupt does not follow flag and enable");
   pwm_only_a: assert property (|pwm_time_base |-> $past(match) && |$past(pwm_mode))
      else $error("time base to module not in PWM mode");

   wrap_c:  cover property (match ##[1:300] match);
   flag_c:  cover property (post_event && wr_status && bus_req.wdata[FLAG_BIT]);
   irq_c:   cover property ($rose(irq));
   clear_c: cover property (wr_ctrl && ctrl_reg.timer_on);
   div16_c: cover property (pre_tick && ctrl_reg.prescale_select[1]);

   // ----------------------------------------------------------------
   // Register and output checks
   // ----------------------------------------------------------------
   // Read data is compared with the state one cycle back, since the
   // read port is registered and the state may move in between.
   flag_clear_a: assert property (
      flag_reg && wr_status && bus_req.wdata[FLAG_BIT] && !post_event |=> !flag_reg)
      else $error("flag not cleared by write of one");
   flag_quiet_a: assert property (!flag_reg && !post_event |=> !flag_reg)
      else $error("flag set without postscaler event");
   flag_rise_a: assert property ($rose(flag_reg) |-> $past(post_event))
      else $error("flag rose without event");
   period_keep_a: assert property (!wr_period |=> $stable(period_reg))
      else $error("period changed without write");
   ctrl_keep_reg_a: assert property (!wr_ctrl |=> $stable(ctrl_reg))
      else $error("control changed without write");
   mask_set_a: assert property (
      wr_mask |=> enable_reg == $past(bus_req.wdata[FLAG_BIT]))
      else $error("mask write not stored");
   mask_keep_a: assert property (!wr_mask |=> $stable(enable_reg))
      else $error("mask changed without write");
   rd_count_a: assert property (
      bus_req.rd && bus_req.addr == OFS_COUNT |=> rdata == $past(count_reg))
      else $error("count read wrong");
   rd_period_a: assert property (
      bus_req.rd && bus_req.addr == OFS_PERIOD |=> rdata == $past(period_reg))
      else $error("period read wrong");
   rd_ctrl_a: assert property (
      bus_req.rd && bus_req.addr == OFS_CONTROL |=> rdata == {1'b0, $past(ctrl_reg)})
      else $error("control read wrong");
   rd_status_a: assert property (
      bus_req.rd && bus_req.addr == OFS_STATUS
      |=> rdata == ($past(flag_reg) ? FLAG_MASK : 8'h00))
      else $error("status read wrong");
   rd_mask_a: assert property (
      bus_req.rd && bus_req.addr == OFS_MASK
      |=> rdata == ($past(enable_reg) ? FLAG_MASK : 8'h00))
      else $error("mask read wrong");
   rd_idle_a: assert property (!bus_req.rd |=> rdata == 8'h00)
      else $error("read data outside read cycle");
   irq_off_a: assert property (!flag_reg |=> !irq)
      else $error("interrupt without flag");
   irq_masked_a: assert property (!enable_reg |=> !irq)
      else $error("interrupt while disabled");
   irq_on_a: assert property (flag_reg && enable_reg |=> irq)
      else $error("interrupt missing");

   // ----------------------------------------------------------------
   // Counter and time base checks
   // ----------------------------------------------------------------
   // A scaler clear must swallow the tick of its own cycle, otherwise
   // a write could both reload and advance the count.
   match_tick_a: assert property (match |-> pre_tick && period_hit)
      else $error("match without tick at period");
   match_off_a: assert property (!ctrl_reg.timer_on |-> !match)
      else $error("match while timer off");
   tick_on_a: assert property (pre_tick |-> ctrl_reg.timer_on)
      else $error("tick while timer off");
   post_match_a: assert property (post_event |-> match)
      else $error("postscaler event without match");
   ctrl_tick_a: assert property (wr_ctrl |-> !pre_tick)
      else $error("tick in control write cycle");
   count_tick_a: assert property (wr_count |-> !pre_tick && !match)
      else $error("tick in count write cycle");
   count_hold_a: assert property (!pre_tick && !wr_count |=> $stable(count_reg))
      else $error("count moved without tick");
   match_zero_a: assert property (match_reg |-> count_reg == 8'h00)
      else $error("count not zero after match");
   tb_pulse0_a: assert property (match && pwm_mode[0] |=> pwm_time_base[0])
      else $error("time base pulse missing on module zero");
   tb_pulse1_a: assert property (match && pwm_mode[1] |=> pwm_time_base[1])
      else $error("time base pulse missing on module one");
   tb_idle_a: assert property (!match |=> pwm_time_base == '0)
      else $error("time base pulse without match");
   tb_mode_a: assert property (!pwm_mode[0] |=> !pwm_time_base[0])
      else $error("time base to module zero outside PWM mode");

endmodule
`default_nettype wire

/* File: tb/tbt_timer_test.sv */
`timescale 1ns/1ps
`default_nettype none
module tbt_timer_test
   import tbt_pkg::*;
   ;

   // ------------------------------------------------------------
   // Clock, reset and design
   // ------------------------------------------------------------
   logic               core_clk     = 1'b0;
   logic               rst          = 1'b1;
   tbt_bus_req_t       bus_req      = '0;
   logic [DATA_W-1:0]  rdata;
   logic [1:0]         pwm_mode     = 2'h0;
   logic [1:0]         pwm_time_base;
   logic               irq;
   int                 err_total    = 0;
   int                 total_checks = 0;
   int                 seed         = 32'hDD08;
   int                 pulse_cnt [2];
   logic [7:0]         d;

   always #25 core_clk = ~core_clk;

   tbt_timer #(.NUM_PWM(2)) i_dut (
      .core_clk      (core_clk),
      .rst           (rst),
      .bus_req       (bus_req),
      .rdata         (rdata),
      .pwm_mode      (pwm_mode),
      .pwm_time_base (pwm_time_base),
      .irq           (irq)
   );

   // Old value of the pulse is seen here, so no race with the design's edge
   always @(posedge core_clk) begin
      for (int b = 0; b < 2; b++) begin
         if (pwm_time_base[b] === 1'b1)
            pulse_cnt[b] <= pulse_cnt[b] + 1;
      end
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One strobe cycle; read data stand only in the cycle after the strobe
   task automatic bus(input logic wr, input logic [2:0] addr, input logic [7:0] wdata,
                      output logic [7:0] data);
      @(posedge core_clk);
      bus_req <= '{wr: wr, rd: ~wr, addr: addr, wdata: wdata};
      @(posedge core_clk);
      bus_req <= '0;
      #1 data = rdata;
   endtask

   task automatic rd_chk(input logic [2:0] addr, input logic [7:0] exp);
      logic [7:0] v;
      bus(1'b0, addr, 8'h00, v);
      check({8'h00, v}, {8'h00, exp});
   endtask

   // Counter model: ticks every div edges after a scaler clear
   task automatic model(input int edges, input int div, input int per,
                        inout int cnt, inout int mt);
      for (int j = 1; j <= edges; j++) begin
         if (j % div == 0) begin
            if (cnt == per) begin
               cnt = 0;
               mt++;
            end
            else
               cnt++;
         end
      end
   endtask

   task automatic reset_checks;
      bus(1'b1, 3'h6, 8'hFF, d);
      for (int a = 0; a < 8; a++)
         rd_chk(a[2:0], (a == 2) ? PERIOD_RST : 8'h00);
      check({15'h0, irq}, 16'h0000);
   endtask

   // ------------------------------------------------------------
   // Watchdog
   // ------------------------------------------------------------
   initial begin
      repeat (100000) @(posedge core_clk);
      err_total++;
      complete_run();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] r;
      logic [1:0]  pre;
      logic [3:0]  post;
      logic        en;
      logic        flag;
      int          per, div, c0, c1, k1, k2, c, m1, m2, tot;
      pulse_cnt[0] = 0;
      pulse_cnt[1] = 0;
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      reset_checks();
      for (int i = 0; i < 40; i++) begin
         r    = $random(seed);
         pre  = r[1:0];
         post = r[5:2];
         en   = r[6];
         per  = r[7] ? int'(r[15:8]) : int'(r[11:8]);
         div  = pre[1] ? 16 : (pre[0] ? 4 : 1);
         if (div == 1 && per == 0)
            per = 1;
         r    = $random(seed);
         c0   = r[15:0] % (per + 1);
         c1   = r[31:16] % (per + 1);
         r    = $random(seed);
         k1   = r[15:0] % 300;
         k2   = r[31:16] % 300;
         pwm_mode <= r[1:0];
         // Avoid a match landing on the count write's own edge
         c  = c0;
         m1 = 0;
         model(k1 + 1, div, per, c, m1);
         if ((k1 + 2) % div == 0 && c == per) begin
            k1++;
            c  = c0;
            m1 = 0;
            model(k1 + 1, div, per, c, m1);
         end
         bus(1'b1, OFS_STATUS, FLAG_MASK, d);
         bus(1'b1, OFS_MASK, {8{en}}, d);
         rd_chk(OFS_MASK, en ? FLAG_MASK : 8'h00);
         bus(1'b1, OFS_PERIOD, per[7:0], d);
         bus(1'b1, OFS_COUNT, c0[7:0], d);
         pulse_cnt[0] = 0;
         pulse_cnt[1] = 0;
         bus(1'b1, OFS_CONTROL, {r[31], post, 1'b1, pre}, d);
         repeat (k1) @(posedge core_clk);
         bus(1'b1, OFS_COUNT, c1[7:0], d);
         c  = c1;
         m2 = 0;
         model(k2 + 1, div, per, c, m2);
         repeat (k2) @(posedge core_clk);
         bus(1'b1, OFS_CONTROL, {r[31], post, 1'b0, pre}, d);
         // Long idle gap shows the count has stopped
         repeat (20) @(posedge core_clk);
         rd_chk(OFS_CONTROL, {1'b0, post, 1'b0, pre});
         rd_chk(OFS_COUNT, c[7:0]);
         rd_chk(OFS_PERIOD, per[7:0]);
         flag = (m1 / (post + 1) + m2 / (post + 1)) > 0;
         rd_chk(OFS_STATUS, flag ? FLAG_MASK : 8'h00);
         check({15'h0, irq}, {15'h0, flag & en});
         tot = m1 + m2;
         for (int b = 0; b < 2; b++)
            check(pulse_cnt[b][15:0], pwm_mode[b] ? tot[15:0] : 16'h0000);
         bus(1'b1, OFS_STATUS, FLAG_MASK, d);
         rd_chk(OFS_STATUS, 8'h00);
         repeat (2) @(posedge core_clk);
         #1;
         check({15'h0, irq}, 16'h0000);
      end
      // Second reset in mid-run with registers loaded
      bus(1'b1, OFS_COUNT, 8'h07, d);
      bus(1'b1, OFS_PERIOD, 8'h03, d);
      bus(1'b1, OFS_CONTROL, 8'h7E, d);
      repeat (5) @(posedge core_clk);
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      reset_checks();
      complete_run();
   end

endmodule
`default_nettype wire
